// ---- logic/pft_pkg.sv ----
// Package for the pause frame timer and refresh block
package pft_pkg;
  localparam logic [15:0] PAUSE_TIME_ADDR    = 16'h0170;
  localparam logic [15:0] REFRESH_THRESH_ADDR = 16'h5F40;
  localparam logic [15:0] STATUS_ADDR        = 16'h5F44;
  localparam int          BYTE_TIMES_PER_SLOT = 64;
  localparam int          CLK_PER_BYTE_TIME   = 1;
  localparam int          SLOT_CLKS = BYTE_TIMES_PER_SLOT * CLK_PER_BYTE_TIME;
  localparam logic [6:0]  SLOT_LAST = 7'(SLOT_CLKS - 1);
  localparam logic [15:0] FIELD_RESET = 16'h0000;
  localparam logic [15:0] ZERO16      = 16'h0000;

  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } pft_bus_t;

  typedef struct packed {
    logic        req;
    logic        is_xoff;
    logic [15:0] pause_time;
  } pft_pause_t;
endpackage

// ---- logic/pft_top.sv ----
// Pause frame time value and XOFF refresh timer
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module pft_top (
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic                clk_en,
  input  wire pft_pkg::pft_bus_t   bus,
  output logic [31:0]              rdata,
  input  wire logic                above_low_thresh,
  input  wire logic                xoff_sent,
  input  wire logic                sw_pause_req,
  output pft_pkg::pft_pause_t      pause_out,
  output logic                     slot_tick
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [15:0] pause_time_value_reg;
  logic [15:0] refresh_threshold_value_reg;
  logic [15:0] shadow_reg;
  logic [15:0] shadow_next;
  logic [6:0]  slot_cnt_reg;
  logic        above_s1_reg;
  logic        above_s2_reg;
  logic [31:0] rdata_next;
  pft_pkg::pft_pause_t pause_next;

  wire hit_time = bus.addr == pft_pkg::PAUSE_TIME_ADDR;
  wire hit_thr  = bus.addr == pft_pkg::REFRESH_THRESH_ADDR;
  wire hit_stat = bus.addr == pft_pkg::STATUS_ADDR;
  wire slot_end = slot_cnt_reg == pft_pkg::SLOT_LAST;
  wire refresh_on = refresh_threshold_value_reg != pft_pkg::ZERO16;
  wire refresh_fire = refresh_on && above_s2_reg && !xoff_sent &&
                      shadow_reg >= refresh_threshold_value_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Read decode
  assign rdata_next = hit_time ? {16'h0000, pause_time_value_reg} :
                      hit_thr  ? {16'h0000, refresh_threshold_value_reg} :
                      hit_stat ? {16'h0000, shadow_reg} :
                      32'h0000_0000;

  assign shadow_next = (xoff_sent || refresh_fire) ? pft_pkg::ZERO16 :
                       (above_s2_reg && refresh_on && slot_end) ?
                       shadow_reg + 16'h0001 : shadow_reg;

  assign pause_next.req        = refresh_fire || sw_pause_req;
  assign pause_next.is_xoff    = refresh_fire;
  assign pause_next.pause_time = pause_time_value_reg;

  ////////////////////////////////////////////////////////////////////////////
  // State
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pause_time_value_reg        <= pft_pkg::FIELD_RESET;
      refresh_threshold_value_reg <= pft_pkg::FIELD_RESET;
      shadow_reg   <= pft_pkg::ZERO16;
      slot_cnt_reg <= 7'h00;
      above_s1_reg <= 1'b0;
      above_s2_reg <= 1'b0;
      rdata        <= 32'h0000_0000;
      pause_out    <= '0;
    end
    else if (clk_en)
    begin
      if (bus.wr && hit_time)
        pause_time_value_reg <= bus.wdata[15:0];
      if (bus.wr && hit_thr)
        refresh_threshold_value_reg <= bus.wdata[15:0];
      slot_cnt_reg <= slot_end ? 7'h00 : slot_cnt_reg + 7'h01;
      above_s1_reg <= above_low_thresh;
      above_s2_reg <= above_s1_reg;
      shadow_reg   <= shadow_next;
      rdata        <= bus.rd ? rdata_next : 32'h0000_0000;
      pause_out    <= pause_next;
    end
  end

  assign slot_tick = slot_end;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_refresh;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && refresh_fire) |=> (pause_out.req && pause_out.is_xoff);
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh xoff missing");

  property p_zero_off;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && refresh_threshold_value_reg == 16'h0000) |=> !pause_out.is_xoff;
  endproperty
  a_zero_off: assert property (p_zero_off) else $error("refresh while disabled");

  property p_upper;
    @(posedge clk) disable iff (sys_rst)
      $past(bus.rd) |-> rdata[31:16] == 16'h0000;
  endproperty
  a_upper: assert property (p_upper) else $error("upper bits not zero");

  property p_time;
    @(posedge clk) disable iff (sys_rst)
      pause_out.req |-> pause_out.pause_time == $past(pause_time_value_reg);
  endproperty
  a_time: assert property (p_time) else $error("pause time mismatch");

  property p_clear;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && xoff_sent) |=> shadow_reg == 16'h0000;
  endproperty
  a_clear: assert property (p_clear) else $error("shadow not cleared");

  property p_step;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && !slot_end && !xoff_sent && !refresh_fire) |=> $stable(shadow_reg);
  endproperty
  a_step: assert property (p_step) else $error("shadow moved mid slot");

  property p_halt;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && !above_s2_reg && !xoff_sent) |=> $stable(shadow_reg);
  endproperty
  a_halt: assert property (p_halt) else $error("shadow counted when drained");

  property p_wr;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && bus.wr && hit_thr) |=> refresh_threshold_value_reg == $past(bus.wdata[15:0]);
  endproperty
  a_wr: assert property (p_wr) else $error("threshold write lost");

  sequence s_fire;
    clk_en && refresh_fire;
  endsequence

  sequence s_xoff_out;
    pause_out.req && pause_out.is_xoff &&
    pause_out.pause_time == $past(pause_time_value_reg);
  endsequence

  property p_refresh_time;
    @(posedge clk) disable iff (sys_rst)
      s_fire |=> s_xoff_out;
  endproperty
  a_refresh_time: assert property (p_refresh_time) else $error("refresh time wrong");

  property p_sw_pause;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && sw_pause_req) |=> pause_out.req;
  endproperty
  a_sw_pause: assert property (p_sw_pause) else $error("pause request lost");

  property p_sw_time;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && sw_pause_req) |=> pause_out.pause_time == $past(pause_time_value_reg);
  endproperty
  a_sw_time: assert property (p_sw_time) else $error("pause value wrong");

  property p_no_spont;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && !refresh_fire && !sw_pause_req) |=> !pause_out.req;
  endproperty
  a_no_spont: assert property (p_no_spont) else $error("pause without cause");

  property p_drained;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && !above_s2_reg) |=> !pause_out.is_xoff;
  endproperty
  a_drained: assert property (p_drained) else $error("refresh when drained");

  property p_fire_clear;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && refresh_fire) |=> shadow_reg == 16'h0000;
  endproperty
  a_fire_clear: assert property (p_fire_clear) else $error("shadow kept after refresh");

  property p_count;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && slot_end && above_s2_reg && refresh_on && !xoff_sent && !refresh_fire)
      |=> shadow_reg == $past(shadow_reg) + 16'h0001;
  endproperty
  a_count: assert property (p_count) else $error("shadow missed slot");

  property p_slot_wrap;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && slot_end) |=> slot_cnt_reg == 7'h00;
  endproperty
  a_slot_wrap: assert property (p_slot_wrap) else $error("slot did not wrap");

  property p_slot_inc;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && !slot_end) |=> slot_cnt_reg == $past(slot_cnt_reg) + 7'h01;
  endproperty
  a_slot_inc: assert property (p_slot_inc) else $error("slot count skipped");

  property p_freeze;
    @(posedge clk) disable iff (sys_rst)
      !clk_en |=> $stable(shadow_reg) && $stable(slot_cnt_reg);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");

  property p_time_wr;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && bus.wr && hit_time) |=> pause_time_value_reg == $past(bus.wdata[15:0]);
  endproperty
  a_time_wr: assert property (p_time_wr) else $error("pause time write lost");

  property p_rd_time;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && bus.rd && hit_time) |=> rdata == {16'h0000, $past(pause_time_value_reg)};
  endproperty
  a_rd_time: assert property (p_rd_time) else $error("pause time read wrong");

  property p_rd_thr;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && bus.rd && hit_thr)
      |=> rdata == {16'h0000, $past(refresh_threshold_value_reg)};
  endproperty
  a_rd_thr: assert property (p_rd_thr) else $error("threshold read wrong");

  property p_rd_idle;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && !bus.rd) |=> rdata == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
endmodule

// ---- bench/pft_partner.sv ----
// Link partner model that logs received XOFF frames
`timescale 1ns/1ps
module pft_partner (
  input  wire logic                clk,
  input  wire pft_pkg::pft_pause_t pause_in,
  output int                       n_xoff,
  output int                       gap,
  output logic [15:0]              last_time
);
  int stamp = 0;
  int last = 0;
  int cnt = 0;
  assign n_xoff = cnt;
  always @(posedge clk)
  begin
    stamp <= stamp + 1;
    if (pause_in.req && pause_in.is_xoff)
    begin
      cnt <= cnt + 1;
      gap <= stamp - last;
      last <= stamp;
      last_time <= pause_in.pause_time;
    end
  end
endmodule

// ---- bench/testbench.sv ----
// Bench for the pause timer and refresh block
`timescale 1ns/1ps
module testbench;
  logic clk = 0, sys_rst = 1, above = 0, swp = 0, xs = 0, ce = 1, st;
  pft_pkg::pft_bus_t b = '0;
  pft_pkg::pft_pause_t po;
  logic [31:0] rdata, pause_time_value;
  logic [15:0] lt;
  int fails = 0, n_checks = 0, seed = 32'h66bc, n, gap, k;
  pft_top DUT (.clk(clk), .sys_rst(sys_rst), .clk_en(ce), .bus(b), .rdata(rdata),
    .above_low_thresh(above), .xoff_sent(xs), .sw_pause_req(swp), .pause_out(po),
    .slot_tick(st));
  pft_partner LP (.clk(clk), .pause_in(po), .n_xoff(n), .gap(gap), .last_time(lt));
  initial forever #2 clk = ~clk;
  function logic [31:0] low16(input logic [31:0] d);
    return {16'h0000, d[15:0]};
  endfunction
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task print_verdict;
    $display("fails %0d checks %0d", fails, n_checks);
    if (fails == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // One bus cycle, sampled mid-cycle after it
  task acc(input logic [15:0] a, input logic [31:0] d, input logic w);
    @(posedge clk);
    b <= '{a, d, w, !w};
    @(posedge clk);
    b <= '0;
    @(negedge clk);
  endtask
  task wait_tick;
    for (int i = 0; !st; i++)
    begin
      if (i == 100)
      begin
        fails++;
        print_verdict;
      end
      @(negedge clk);
    end
  endtask
  task await_n(input int t);
    for (int i = 0; n < t; i++)
    begin
      if (i == 1000)
      begin
        fails++;
        print_verdict;
      end
      @(posedge clk);
    end
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    sys_rst <= 0;
    for (int i = 0; i < 5; i++)
    begin
      pause_time_value = (i == 0) ? 32'h0 : $random(seed);
      acc(pft_pkg::PAUSE_TIME_ADDR, pause_time_value, 1);
      acc(pft_pkg::PAUSE_TIME_ADDR, 32'h0, 0);
      chk(rdata, low16(pause_time_value));
      @(posedge clk);
      swp <= 1;
      @(posedge clk);
      swp <= 0;
      @(negedge clk);
      chk({14'h0, po.req, po.is_xoff, po.pause_time}, {14'h0, 2'b10, pause_time_value[15:0]});
    end
    acc(16'h0004, 32'h0, 0);
    chk(rdata, 32'h0);
    acc(pft_pkg::REFRESH_THRESH_ADDR, 32'hFFFF0002, 1);
    acc(pft_pkg::REFRESH_THRESH_ADDR, 32'h0, 0);
    chk(rdata, 32'h2);
    @(posedge clk);
    above <= 1;
    await_n(n + 2);
    chk(gap, 2 * pft_pkg::SLOT_CLKS);
    chk({16'h0, lt}, low16(pause_time_value));
    above <= 0;
    repeat (4) @(posedge clk);
    k = n;
    repeat (300) @(posedge clk);
    chk(n, k);
    acc(pft_pkg::REFRESH_THRESH_ADDR, 32'h0, 1);
    @(posedge clk);
    above <= 1;
    repeat (300) @(posedge clk);
    chk(n, k);
    // Slot period seen on the tick output
    acc(pft_pkg::REFRESH_THRESH_ADDR, 32'h0100, 1);
    wait_tick;
    k = 0;
    do
    begin
      @(negedge clk);
      k++;
    end
    while (!st && k < 200);
    chk(k, pft_pkg::SLOT_CLKS);
    // Transmitted XOFF clears the shadow count
    @(posedge clk);
    xs <= 1;
    @(posedge clk);
    xs <= 0;
    acc(pft_pkg::STATUS_ADDR, 32'h0, 0);
    chk(rdata, 32'h0);
    repeat (3)
    begin
      @(negedge clk);
      wait_tick;
    end
    @(posedge clk);
    acc(pft_pkg::STATUS_ADDR, 32'h0, 0);
    chk(rdata, 32'h3);
    // Writes are ignored while the clock enable is low
    @(posedge clk);
    ce <= 0;
    acc(pft_pkg::PAUSE_TIME_ADDR, 32'h0000_1234, 1);
    @(posedge clk);
    ce <= 1;
    acc(pft_pkg::PAUSE_TIME_ADDR, 32'h0, 0);
    chk(rdata, low16(pause_time_value));
    // Reset in mid run returns the fields to their reset value
    @(posedge clk);
    sys_rst <= 1;
    repeat (2) @(posedge clk);
    sys_rst <= 0;
    acc(pft_pkg::PAUSE_TIME_ADDR, 32'h0, 0);
    chk(rdata, {16'h0, pft_pkg::FIELD_RESET});
    print_verdict;
  end
endmodule
